// ---- hw/lps_core.sv ----
/*
  Protection policy control register, output voltage select register and first
  diagnostic status register, with recovery sequencing after overload and overtemperature.
  Assumes a byte register port (address, write strobe, read strobe) from a bus engine,
  and comparator levels arriving asynchronously from the analog side.
*/
// Contract
// - Policy control register is read/write at address 0x5.
// - All policy control bits clear to zero at reset.
// - Bit 0 enables the minimum-current diagnostic, raising output to diagnostic level.
// - Overload with bit 3 set clears voltage select and disables output.
// - Bit 3 clear: output returns with old select once overload clears.
// - Overtemperature with bit 6 set clears voltage select and disables output.
// - Bit 6 clear: output returns with old select once overtemperature clears.
// - Bit 7 selects high-ESR compensation when one, low-ESR when zero.
// - Status registers are read only; writes to them are ignored.
// - First status at address 0x0, second status at 0x1.
// - Status bit 0 shows overload protection active.
// - Status bit 2 shows output voltage below monitor threshold.
// - Status bit 4 set only after pull-down overcurrent outlasts deglitch time.
// - Status bit 6 sets above 150 C, clears below 135 C.
// - Status bit 7 shows input supply below power-good threshold.
// - Voltage select occupies bits 0 to 3 of register 0x2.
// - Data register 0x2 reads back the low four bits of the last written byte, upper bits zero; a locking trip clears the low bits to zero.
module lps_core
  import lps_pkg::*;
#(
  parameter int DEGLITCH_CYC = LPS_DEGLITCH_CYC
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic regRvalid,
  // Second status register contents from elsewhere
  input wire logic [7:0] status2In,
  // Analog comparator levels
  input wire logic overloadIn,
  input wire logic vLowIn,
  input wire logic pdOvercurrentIn,
  input wire logic tempAbove150In,
  input wire logic tempBelow135In,
  input wire logic powerNotGoodIn,
  // Controls to the analog side
  output logic [3:0] outputVoltageSelect,
  output logic outputEnable,
  output logic minCurrentDiagEnable,
  output logic compHighEsr
);
  typedef enum logic [2:0] {
    LPS_RUN = 3'b001,
    LPS_HOLD = 3'b010,
    LPS_LOCKED = 3'b100
  } lps_state_t;

  typedef struct packed {
    lps_state_t fsm;
    logic [7:0] policy;
    logic [3:0] output_voltage_select;
    logic overtemp;
    logic pdFlag;
    logic [15:0] pdCount;
    logic [7:0] rdata;
    logic rvalid;
  } lps_core_t;

  lps_core_t st;
  lps_core_t next_st;
  lps_sense_if sense();
  logic [5:0] syncLevels;
  logic [7:0] status1;
  logic tripOl;
  logic tripOt;
  logic lockOnTrip;

  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] target);
    addrHit = (a == target);
  endfunction

  lps_sync #(
    .WIDTH(6)
  ) uSync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rawIn({powerNotGoodIn, tempBelow135In, tempAbove150In, pdOvercurrentIn, vLowIn,
      overloadIn}),
    .syncOut(syncLevels)
  );

  assign sense.overload = syncLevels[0];
  assign sense.vLow = syncLevels[1];
  assign sense.pdRaw = syncLevels[2];
  assign sense.otHot = syncLevels[3];
  assign sense.otCool = syncLevels[4];
  assign sense.input_power_not_good_flag = syncLevels[5];

  // Live status byte, reserved bits zero
  always_comb
  begin
    status1 = 8'h00;
    status1[LPS_BIT_OLF] = sense.overload;
    status1[LPS_BIT_VLOW] = sense.vLow;
    status1[LPS_BIT_PDO] = st.pdFlag;
    status1[LPS_BIT_OTF] = st.overtemp;
    status1[LPS_BIT_PNG] = sense.input_power_not_good_flag;
  end

  assign tripOl = sense.overload;
  assign tripOt = st.overtemp;
  // Trip with its own lock-type policy bit set (overload bit 3, overtemperature bit 6) clears the select
  assign lockOnTrip = (tripOl && st.policy[LPS_BIT_OL_REC])
    || (tripOt && st.policy[LPS_BIT_TH_REC]);

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;

    // Overtemperature with hysteresis
    if (sense.otHot)
      next_st.overtemp = 1'b1;
    else if (sense.otCool)
      next_st.overtemp = 1'b0;

    // Pull-down overcurrent deglitch
    if (!sense.pdRaw)
    begin
      next_st.pdCount = '0;
      next_st.pdFlag = 1'b0;
    end
    else if (st.pdCount >= 16'(DEGLITCH_CYC))
      next_st.pdFlag = 1'b1;
    else
      next_st.pdCount = st.pdCount + 16'h0001;

    // Register writes; status addresses take no write
    if (regWrite)
    begin
      if (addrHit(regAddr, LPS_ADDR_POLICY))
        next_st.policy = regWdata & LPS_POLICY_MASK;
      else if (addrHit(regAddr, LPS_ADDR_DATA1))
        next_st.output_voltage_select = regWdata[3:0];
    end

    // Recovery sequencing
    case (st.fsm)
      LPS_RUN:
      begin
        if (lockOnTrip)
          next_st.fsm = LPS_LOCKED;
        else if (tripOl || tripOt)
          next_st.fsm = LPS_HOLD;
      end
      LPS_HOLD:
      begin
        if (lockOnTrip)
          next_st.fsm = LPS_LOCKED;
        else if (!tripOl && !tripOt)
          next_st.fsm = LPS_RUN;
      end
      LPS_LOCKED:
      begin
        if (!tripOl && !tripOt)
          next_st.fsm = LPS_RUN;
      end
      default:
        next_st.fsm = LPS_RUN;
    endcase

    // Trip clear wins over a simultaneous select write
    if (lockOnTrip || (st.fsm == LPS_LOCKED && (tripOl || tripOt)))
      next_st.output_voltage_select = 4'h0;

    // Read data, sampled live at the read strobe
    if (regRead)
    begin
      next_st.rvalid = 1'b1;
      if (addrHit(regAddr, LPS_ADDR_STATUS1))
        next_st.rdata = status1;
      else if (addrHit(regAddr, LPS_ADDR_STATUS2))
        next_st.rdata = status2In;
      else if (addrHit(regAddr, LPS_ADDR_DATA1))
        next_st.rdata = {4'h0, st.output_voltage_select};
      else if (addrHit(regAddr, LPS_ADDR_POLICY))
        next_st.rdata = st.policy;
      else
        next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st.fsm <= LPS_RUN;
      st.policy <= LPS_POLICY_RESET;
      st.output_voltage_select <= LPS_DATA1_RESET[3:0];
      st.overtemp <= 1'b0;
      st.pdFlag <= 1'b0;
      st.pdCount <= '0;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign regRdata = st.rdata;
  assign regRvalid = st.rvalid;
  assign outputVoltageSelect = st.output_voltage_select;
  // Output off while any trip is active or the select is zero; on with held select otherwise
  assign outputEnable = (st.fsm == LPS_RUN) && (st.output_voltage_select != 4'h0);
  assign minCurrentDiagEnable = st.policy[LPS_BIT_DIAG_EN];
  assign compHighEsr = st.policy[LPS_BIT_COMP];
endmodule // lps_core

// ---- hw/lps_pkg.sv ----
/*
  Package for the protection and status register bank: addresses, field positions,
  reset values and deglitch timing.
  Assumes a byte-wide register port driven by a serial bus engine outside this block.
*/
package lps_pkg;
  localparam logic [7:0] LPS_ADDR_STATUS1 = 8'h00;
  localparam logic [7:0] LPS_ADDR_STATUS2 = 8'h01;
  localparam logic [7:0] LPS_ADDR_DATA1 = 8'h02;
  localparam logic [7:0] LPS_ADDR_POLICY = 8'h05;
  localparam logic [7:0] LPS_POLICY_RESET = 8'h00;
  localparam logic [7:0] LPS_DATA1_RESET = 8'h00;
  localparam logic [7:0] LPS_POLICY_MASK = 8'hC9;
  localparam logic [7:0] LPS_DATA1_MASK = 8'h0F;
  localparam int LPS_BIT_DIAG_EN = 0;
  localparam int LPS_BIT_OL_REC = 3;
  localparam int LPS_BIT_TH_REC = 6;
  localparam int LPS_BIT_COMP = 7;
  localparam int LPS_BIT_OLF = 0;
  localparam int LPS_BIT_VLOW = 2;
  localparam int LPS_BIT_PDO = 4;
  localparam int LPS_BIT_OTF = 6;
  localparam int LPS_BIT_PNG = 7;
  localparam int LPS_DEGLITCH_NS = 1000;
  localparam int LPS_CLK_NS = 50;
  localparam int LPS_DEGLITCH_CYC = (LPS_DEGLITCH_NS + LPS_CLK_NS - 1) / LPS_CLK_NS;
endpackage

// ---- hw/lps_sense_if.sv ----
/*
  Interface carrying synchronised condition levels between sense front end and core.
  Assumes one clock domain.
*/
interface lps_sense_if;
  logic overload;
  logic vLow;
  logic pdRaw;
  logic otHot;
  logic otCool;
  logic input_power_not_good_flag;
  modport src (output overload, vLow, pdRaw, otHot, otCool, input_power_not_good_flag);
  modport dst (input overload, vLow, pdRaw, otHot, otCool, input_power_not_good_flag);
endinterface

// ---- hw/lps_sync.sv ----
/*
  Two-flop synchroniser for the analog comparator levels.
  Assumes asynchronous comparator outputs.
*/
module lps_sync
  import lps_pkg::*;
#(
  parameter int WIDTH = 6
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw and synchronised levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } lps_sync_t;
  lps_sync_t st;
  lps_sync_t next_st;
  always_comb
  begin
    next_st.stage1 = rawIn;
    next_st.stage2 = st.stage1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
  assign syncOut = st.stage2;
endmodule // lps_sync

// ---- verification/lnb_protection_status_registers_tb_top.sv ----
/* Self-checking bench for the protection and status register core.
   Assumes the host model and checker files are compiled before it. */
module lnb_protection_status_registers_tb_top
  import lps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic overloadIn = 1'b0;
  logic vLowIn = 1'b0;
  logic pdOvercurrentIn = 1'b0;
  logic tempAbove150In = 1'b0;
  logic tempBelow135In = 1'b1;
  logic powerNotGoodIn = 1'b0;
  logic [7:0] status2In = 8'h5A;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regWrite, regRead, regRvalid, outputEnable, minCurrentDiagEnable, compHighEsr;
  logic [3:0] outputVoltageSelect;
  int error_cnt = 0;
  int total_checks = 0;
  initial forever #25 clk_sys = ~clk_sys;
  lps_host i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .regRvalid(regRvalid));
  lps_core #(.DEGLITCH_CYC(3)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .regRvalid(regRvalid), .status2In(status2In), .overloadIn(overloadIn), .vLowIn(vLowIn),
    .pdOvercurrentIn(pdOvercurrentIn), .tempAbove150In(tempAbove150In),
    .tempBelow135In(tempBelow135In), .powerNotGoodIn(powerNotGoodIn),
    .outputVoltageSelect(outputVoltageSelect), .outputEnable(outputEnable),
    .minCurrentDiagEnable(minCurrentDiagEnable), .compHighEsr(compHighEsr));
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a);
    check(i_host.lastRd, exp);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task t_policy;
    rchk(LPS_ADDR_POLICY, LPS_POLICY_RESET);
    i_host.wr(LPS_ADDR_POLICY, 8'hFF);
    rchk(LPS_ADDR_POLICY, 8'hC9);
    check({6'h0, minCurrentDiagEnable, compHighEsr}, 8'h03);
    i_host.wr(LPS_ADDR_POLICY, 8'h00);
    wt(1);
    check({6'h0, minCurrentDiagEnable, compHighEsr}, 8'h00);
    i_host.wr(LPS_ADDR_DATA1, 8'hF5);
    rchk(LPS_ADDR_DATA1, 8'h05);
  endtask
  task t_status;
    i_host.wr(LPS_ADDR_STATUS1, 8'hFF);
    i_host.wr(LPS_ADDR_STATUS2, 8'hFF);
    {vLowIn, powerNotGoodIn, tempAbove150In, tempBelow135In} <= 4'hE;
    wt(4);
    rchk(LPS_ADDR_STATUS1, 8'hC4);
    rchk(LPS_ADDR_STATUS1, 8'hC4);
    rchk(LPS_ADDR_STATUS2, 8'h5A);
    rchk(8'h07, 8'h00);
    {vLowIn, powerNotGoodIn, tempAbove150In} <= 3'h0;
    wt(4);
    rchk(LPS_ADDR_STATUS1, 8'h40);
    tempBelow135In <= 1'b1;
    wt(4);
    rchk(LPS_ADDR_STATUS1, 8'h00);
  endtask
  task t_pdo;
    pdOvercurrentIn <= 1'b1;
    wt(3);
    pdOvercurrentIn <= 1'b0;
    wt(4);
    rchk(LPS_ADDR_STATUS1, 8'h00);
    pdOvercurrentIn <= 1'b1;
    wt(8);
    rchk(LPS_ADDR_STATUS1, 8'h10);
    pdOvercurrentIn <= 1'b0;
    wt(4);
    rchk(LPS_ADDR_STATUS1, 8'h00);
  endtask
  task t_trip(input logic th, input logic lock);
    i_host.wr(LPS_ADDR_POLICY, {1'b0, lock & th, 2'h0, lock & ~th, 3'h0});
    i_host.wr(LPS_ADDR_DATA1, 8'h05);
    {overloadIn, tempAbove150In, tempBelow135In} <= th ? 3'h2 : 3'h5;
    wt(5);
    check({3'h0, outputEnable, outputVoltageSelect}, lock ? 8'h00 : 8'h05);
    rchk(LPS_ADDR_STATUS1, th ? 8'h40 : 8'h01);
    {overloadIn, tempAbove150In, tempBelow135In} <= 3'h1;
    wt(5);
    check({3'h0, outputEnable, outputVoltageSelect}, lock ? 8'h00 : 8'h15);
    i_host.wr(LPS_ADDR_DATA1, 8'h05);
    wt(1);
    check({3'h0, outputEnable, outputVoltageSelect}, 8'h15);
  endtask
  initial
  begin
    wt(12);
    rst_n <= 1'b1;
    t_policy;
    t_status;
    t_pdo;
    t_trip(1'b0, 1'b1);
    t_trip(1'b0, 1'b0);
    t_trip(1'b1, 1'b1);
    t_trip(1'b1, 1'b0);
    i_host.wr(LPS_ADDR_POLICY, 8'hC9);
    rst_n <= 1'b0;
    wt(3);
    rst_n <= 1'b1;
    rchk(LPS_ADDR_POLICY, 8'h00);
    conclude;
  end
  initial
  begin
    #4000000;
    error_cnt++;
    conclude;
  end
endmodule // lnb_protection_status_registers_tb_top
bind lps_core lps_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .regRvalid(regRvalid), .overloadIn(overloadIn), .outputVoltageSelect(outputVoltageSelect),
  .outputEnable(outputEnable), .minCurrentDiagEnable(minCurrentDiagEnable),
  .compHighEsr(compHighEsr));

// ---- verification/lps_host.sv ----
/* Host model issuing single-byte register writes and reads.
   Assumes the core's strobe port and one clock. */
module lps_host
  import lps_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lastRd;
  initial {regAddr, regWdata, regWrite, regRead} = '0;
  // Data line inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  // A missing valid pulse shows as inverted data
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    // Sample mid-cycle, while the one-cycle valid pulse stands settled
    @(negedge clk_sys);
    lastRd = regRvalid ? regRdata : ~regRdata;
    @(posedge clk_sys);
  endtask
endmodule // lps_host

// ---- verification/lps_monitor.sv ----
/* Checker for the protection and status register bank core.
   Bound from the bench top; sees only the core's ports. */
module lps_monitor
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  // Conditions and controls
  input wire logic overloadIn,
  input wire logic [3:0] outputVoltageSelect,
  input wire logic outputEnable,
  input wire logic minCurrentDiagEnable,
  input wire logic compHighEsr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic overload_recovery_policy;
  logic polWr;
  assign polWr = regWrite && regAddr == LPS_ADDR_POLICY;
  // Shadow of the overload lock bit
  always_ff @(posedge clk_sys)
    if (!rst_n)
      overload_recovery_policy <= 1'b0;
    else if (polWr)
      overload_recovery_policy <= regWdata[LPS_BIT_OL_REC];
  property p_rst; $rose(rst_n) |-> !minCurrentDiagEnable && !compHighEsr && !outputEnable; endproperty
  property p_rv; regRvalid == $past(regRead); endproperty
  property p_diag; polWr |=> minCurrentDiagEnable == $past(regWdata[LPS_BIT_DIAG_EN]); endproperty
  property p_comp; polWr |=> compHighEsr == $past(regWdata[LPS_BIT_COMP]); endproperty
  property p_ro; regWrite && regAddr <= LPS_ADDR_STATUS2 |=> $stable(compHighEsr); endproperty
  property p_unm; regRead && regAddr > LPS_ADDR_POLICY |=> regRdata == 8'h00; endproperty
  property p_off; overloadIn [*5] |=> !outputEnable; endproperty
  property p_lock; overload_recovery_policy && overloadIn [*5] |=> outputVoltageSelect == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  a_rv: assert property (p_rv) else $error("read valid not one cycle after read");
  a_diag: assert property (p_diag) else $error("diag enable differs from bit 0");
  a_comp: assert property (p_comp) else $error("compensation differs from bit 7");
  a_ro: assert property (p_ro) else $error("status write changed policy");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_off: assert property (p_off) else $error("output on during overload");
  a_lock: assert property (p_lock) else $error("select kept under lock");
  c_pol: cover property (polWr && regWdata[LPS_BIT_OL_REC]);
  c_ovl: cover property (overloadIn [*5]);
  c_rd: cover property (regRvalid && regAddr == LPS_ADDR_STATUS1);
endmodule // lps_monitor
